// ---- axis_io_regs.vh ----
// Register offsets, field positions, reset values and timing counts for the axis input block
`ifndef AXIS_IO_REGS_VH
`define AXIS_IO_REGS_VH

// Register word addresses (8-bit address port)
`define ADDR_LIM_EN      8'h00
`define ADDR_LIM_POL     8'h04
`define ADDR_LIM_CFG     8'h08
`define ADDR_LIM_STAT    8'h0c
`define ADDR_LIM_EVT     8'h10
`define ADDR_ENC_POL     8'h14
`define ADDR_ENC_QUAL    8'h18
`define ADDR_ENC_FILT    8'h1c
`define ADDR_REF_ARM     8'h20
`define ADDR_REF_STAT    8'h24
`define ADDR_ENC_CNT0    8'h40
`define ADDR_ENC_CAP0    8'h50

// Field layout of limit registers: per axis, bit 0 fwd, bit 1 rev, bit 2 home
`define LIM_FWD          0
`define LIM_REV          1
`define LIM_HOME         2
`define LIM_BITS         3

// Limit config field
`define CFG_FILT_BYPASS  0

// Reset values
`define LIM_EN_RST       12'h000
`define LIM_POL_RST      12'hfff
`define LIM_CFG_RST      1'h0
`define ENC_POL_RST      12'h000
`define ENC_QUAL_RST     8'h00
`define ENC_FILT_RST     4'h3

// Limit filter time and derived cycle count at 125 MHz
`define LIM_FILT_US      1000
`define CLK_MHZ          125
`define LIM_FILT_CYC     (`LIM_FILT_US * `CLK_MHZ)

`endif

// ---- quad_channel.v ----
// One quadrature channel: noise filters, polarity, x4 decode, 32-bit count, index capture
`include "axis_io_regs.vh"

module quad_channel (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        pha_i,
    input  wire        phb_i,
    input  wire        idx_i,
    input  wire [2:0]  pol_i,
    input  wire [1:0]  qual_i,
    input  wire [3:0]  filt_i,
    input  wire        arm_i,
    output reg  [31:0] count_o,
    output reg  [31:0] cap_o,
    output reg         found_o
);

    reg  [2:0]  raw_q;
    reg  [2:0]  flt_q;
    reg  [3:0]  run_q [0:2];
    reg         a_prev_q;
    reg         b_prev_q;
    reg         z_prev_q;
    wire [2:0]  in_w;
    wire        a_w;
    wire        b_w;
    wire        z_w;
    wire        idx_rise_w;
    integer     k;

    assign in_w = {idx_i, phb_i, pha_i} ^ pol_i;
    assign a_w  = flt_q[0];
    assign b_w  = flt_q[1];
    assign z_w  = flt_q[2];

    ////////////////////////////////////////////////////////////////////////////
    // Noise filter: a level is taken after filt_i + 1 equal samples
    always @(posedge clk_i) begin
        if (rst_i) begin
            raw_q <= 3'h0;
            flt_q <= 3'h0;
            for (k = 0; k < 3; k = k + 1) begin
                run_q[k] <= 4'h0;
            end
        end else begin
            raw_q <= in_w;
            for (k = 0; k < 3; k = k + 1) begin
                if (raw_q[k] == flt_q[k]) begin
                    run_q[k] <= 4'h0;
                end else if (run_q[k] >= filt_i) begin
                    run_q[k] <= 4'h0;
                    flt_q[k] <= raw_q[k];
                end else begin
                    run_q[k] <= run_q[k] + 4'h1;
                end
            end
        end
    end

    // Qualified index: rising index with A/B at the selected state
    assign idx_rise_w = z_w && !z_prev_q && ({b_w, a_w} == qual_i);

    ////////////////////////////////////////////////////////////////////////////
    // x4 decode, wrapping counter, index capture
    always @(posedge clk_i) begin
        if (rst_i) begin
            a_prev_q <= 1'b0;
            b_prev_q <= 1'b0;
            z_prev_q <= 1'b0;
            count_o  <= 32'h0000_0000;
            cap_o    <= 32'h0000_0000;
            found_o  <= 1'b0;
        end else begin
            a_prev_q <= a_w;
            b_prev_q <= b_w;
            z_prev_q <= z_w;
            // Counts even when no axis loop uses the channel
            if ((a_w != a_prev_q) && (b_w != b_prev_q)) begin
                count_o <= count_o;
            end else if ((a_w != a_prev_q) || (b_w != b_prev_q)) begin
                // A leading B counts up, B leading A counts down
                if ((a_w ^ b_prev_q) == 1'b1) begin
                    count_o <= count_o + 32'h0000_0001;
                end else begin
                    count_o <= count_o - 32'h0000_0001;
                end
            end
            // Capture the count standing at the index edge
            if (arm_i && idx_rise_w) begin
                cap_o   <= count_o;
                found_o <= 1'b1;
            end else if (!arm_i) begin
                found_o <= 1'b0;
            end
        end
    end

endmodule

// ---- limit_home_quadrature_inputs.v ----
// Limit/home switch conditioning, axis halt/inhibit and four quadrature counters
//
// Notes on behaviour
// - Software enables each axis forward, reverse and home input any time.
// - An enabled input going active halts its axis at once, full torque.
// - Active enabled forward/reverse limit blocks new motion that way.
// - Limit/home inputs need 1 ms stable unless filter bypass is set.
// - Short limit pulse halts only with filter bypass set; later moves not blocked once inactive.
// - Each limit/home input has software active-low or active-high level.
// - Status of all limit/home inputs always readable; disabled ones too.
// - Four encoder channels, each with phase A, phase B and index.
// - Each channel holds a 32-bit up/down count, one per valid edge.
// - Leading phase sets direction; four counts per encoder line.
// - Qualified index in armed search latches the count at that edge.
// - Default index qualifies at high level with A and B both low.
// - Software picks the A/B index pattern and A, B, index polarity.
// - Phase and index inputs are digitally filtered, filter configurable.
// - A channel no loop uses still counts normally.
`include "axis_io_regs.vh"

module limit_home_quadrature_inputs #(
    parameter [17:0] LIM_FILT_CYC = `LIM_FILT_CYC
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire [7:0]  addr_i,
    input  wire [31:0] wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [31:0] rdata_o,
    input  wire [3:0]  fwd_lim_i,
    input  wire [3:0]  rev_lim_i,
    input  wire [3:0]  home_i,
    input  wire [3:0]  pha_i,
    input  wire [3:0]  phb_i,
    input  wire [3:0]  idx_i,
    input  wire [3:0]  move_pos_req_i,
    input  wire [3:0]  move_neg_req_i,
    output reg  [3:0]  halt_o,
    output reg  [3:0]  move_pos_ok_o,
    output reg  [3:0]  move_neg_ok_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers and wires
    reg  [11:0] lim_en_q;
    reg  [11:0] lim_pol_q;
    reg         bypass_q;
    reg  [11:0] lim_raw_q;
    reg  [11:0] lim_flt_q;
    reg  [11:0] lim_prev_q;
    reg  [11:0] lim_evt_q;
    reg  [17:0] lim_cnt_q [0:11];
    reg  [11:0] enc_pol_q;
    reg  [7:0]  enc_qual_q;
    reg  [3:0]  enc_filt_q;
    reg  [3:0]  ref_arm_q;
    wire [11:0] lim_in_w;
    wire [11:0] lim_act_w;
    wire [11:0] lim_rise_w;
    wire [31:0] cnt_w [0:3];
    wire [31:0] cap_w [0:3];
    wire [3:0]  found_w;
    reg  [31:0] rd_d;
    integer     i;
    integer     j;
    genvar      g;

    // Field selectors sized for the index helper
    localparam [1:0] FLD_FWD = `LIM_FWD;
    localparam [1:0] FLD_REV = `LIM_REV;

    // Block match helper: address in the 16-byte block of a given register base
    function in_block;
        input [7:0] a;
        input [7:0] base;
        begin
            in_block = (a[7:4] == base[7:4]);
        end
    endfunction

    // Per-axis packed index: axis n, field f
    function [3:0] lim_bit;
        input [1:0] axis;
        input [1:0] field;
        begin
            lim_bit = (axis * 4'h3) + {2'b00, field};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin packing and polarity: pol bit 1 means active high
    generate
        for (g = 0; g < 4; g = g + 1) begin : pack
            assign lim_in_w[g*3 + `LIM_FWD]  = fwd_lim_i[g];
            assign lim_in_w[g*3 + `LIM_REV]  = rev_lim_i[g];
            assign lim_in_w[g*3 + `LIM_HOME] = home_i[g];
        end
    endgenerate

    // Active level after polarity, filtered or bypassed
    assign lim_act_w  = bypass_q ? lim_raw_q : lim_flt_q;
    assign lim_rise_w = lim_act_w & ~lim_prev_q & lim_en_q;

    ////////////////////////////////////////////////////////////////////////////
    // Limit/home filter: output follows input after LIM_FILT_CYC stable cycles
    always @(posedge clk_i) begin
        if (rst_i) begin
            lim_raw_q <= 12'h000;
            lim_flt_q <= 12'h000;
            for (i = 0; i < 12; i = i + 1) begin
                lim_cnt_q[i] <= 18'h00000;
            end
        end else begin
            lim_raw_q <= ~(lim_in_w ^ lim_pol_q);
            for (i = 0; i < 12; i = i + 1) begin
                if (lim_raw_q[i] == lim_flt_q[i]) begin
                    lim_cnt_q[i] <= 18'h00000;
                end else if (lim_cnt_q[i] >= LIM_FILT_CYC - 18'h00001) begin
                    lim_cnt_q[i] <= 18'h00000;
                    lim_flt_q[i] <= lim_raw_q[i];
                end else begin
                    lim_cnt_q[i] <= lim_cnt_q[i] + 18'h00001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Halt pulse and direction permits
    always @(posedge clk_i) begin
        if (rst_i) begin
            lim_prev_q    <= 12'h000;
            halt_o        <= 4'h0;
            move_pos_ok_o <= 4'h0;
            move_neg_ok_o <= 4'h0;
        end else begin
            lim_prev_q <= lim_act_w;
            for (j = 0; j < 4; j = j + 1) begin
                // Any enabled input going active halts, even a short pulse when the filter is bypassed
                halt_o[j] <= |lim_rise_w[j*3 +: 3];
                // Permit follows the live level, so a cleared pulse blocks nothing
                move_pos_ok_o[j] <= move_pos_req_i[j] &
                    ~(lim_act_w[lim_bit(j[1:0], FLD_FWD)] &
                      lim_en_q[lim_bit(j[1:0], FLD_FWD)]);
                move_neg_ok_o[j] <= move_neg_req_i[j] &
                    ~(lim_act_w[lim_bit(j[1:0], FLD_REV)] &
                      lim_en_q[lim_bit(j[1:0], FLD_REV)]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Encoder channels
    generate
        for (g = 0; g < 4; g = g + 1) begin : enc
            quad_channel u_chan (
                .clk_i   (clk_i),
                .rst_i   (rst_i),
                .pha_i   (pha_i[g]),
                .phb_i   (phb_i[g]),
                .idx_i   (idx_i[g]),
                .pol_i   (enc_pol_q[g*3 +: 3]),
                .qual_i  (enc_qual_q[g*2 +: 2]),
                .filt_i  (enc_filt_q),
                .arm_i   (ref_arm_q[g]),
                .count_o (cnt_w[g]),
                .cap_o   (cap_w[g]),
                .found_o (found_w[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Register writes; the event bits clear by writing one, set wins
    always @(posedge clk_i) begin
        if (rst_i) begin
            lim_en_q   <= `LIM_EN_RST;
            lim_pol_q  <= `LIM_POL_RST;
            bypass_q   <= `LIM_CFG_RST;
            enc_pol_q  <= `ENC_POL_RST;
            enc_qual_q <= `ENC_QUAL_RST;
            enc_filt_q <= `ENC_FILT_RST;
            ref_arm_q  <= 4'h0;
            lim_evt_q  <= 12'h000;
        end else begin
            if (wr_i && addr_i == `ADDR_LIM_EVT) begin
                lim_evt_q <= (lim_evt_q & ~wdata_i[11:0]) | lim_rise_w;
            end else begin
                lim_evt_q <= lim_evt_q | lim_rise_w;
            end
            if (wr_i) begin
                if (addr_i == `ADDR_LIM_EN) begin
                    lim_en_q <= wdata_i[11:0];
                end else if (addr_i == `ADDR_LIM_POL) begin
                    lim_pol_q <= wdata_i[11:0];
                end else if (addr_i == `ADDR_LIM_CFG) begin
                    bypass_q <= wdata_i[`CFG_FILT_BYPASS];
                end else if (addr_i == `ADDR_ENC_POL) begin
                    enc_pol_q <= wdata_i[11:0];
                end else if (addr_i == `ADDR_ENC_QUAL) begin
                    enc_qual_q <= wdata_i[7:0];
                end else if (addr_i == `ADDR_ENC_FILT) begin
                    enc_filt_q <= wdata_i[3:0];
                end else if (addr_i == `ADDR_REF_ARM) begin
                    ref_arm_q <= wdata_i[3:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux
    always @* begin
        rd_d = 32'h0000_0000;
        if (addr_i == `ADDR_LIM_EN) begin
            rd_d = {20'h00000, lim_en_q};
        end else if (addr_i == `ADDR_LIM_POL) begin
            rd_d = {20'h00000, lim_pol_q};
        end else if (addr_i == `ADDR_LIM_CFG) begin
            rd_d = {31'h0000_0000, bypass_q};
        end else if (addr_i == `ADDR_LIM_STAT) begin
            rd_d = {20'h00000, lim_act_w};
        end else if (addr_i == `ADDR_LIM_EVT) begin
            rd_d = {20'h00000, lim_evt_q};
        end else if (addr_i == `ADDR_ENC_POL) begin
            rd_d = {20'h00000, enc_pol_q};
        end else if (addr_i == `ADDR_ENC_QUAL) begin
            rd_d = {24'h000000, enc_qual_q};
        end else if (addr_i == `ADDR_ENC_FILT) begin
            rd_d = {28'h0000000, enc_filt_q};
        end else if (addr_i == `ADDR_REF_ARM) begin
            rd_d = {28'h0000000, ref_arm_q};
        end else if (addr_i == `ADDR_REF_STAT) begin
            rd_d = {28'h0000000, found_w};
        end else if (in_block(addr_i, `ADDR_ENC_CNT0) && addr_i[1:0] == 2'b00) begin
            rd_d = cnt_w[addr_i[3:2]];
        end else if (in_block(addr_i, `ADDR_ENC_CAP0) && addr_i[1:0] == 2'b00) begin
            rd_d = cap_w[addr_i[3:2]];
        end
    end

    // Read data registered; stands only the cycle after the strobe
    always @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (rd_i) begin
            rdata_o <= rd_d;
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end

endmodule

// ---- limit_home_quadrature_inputs_monitor.sv ----
// Port checker for bus reads, halt pulses and motion permits
`include "axis_io_regs.vh"
module limit_home_quadrature_inputs_monitor #(
    parameter [17:0] LIM_FILT_CYC = 18'd8
) (
    input logic        clk_i,
    input logic        rst_i,
    input logic [7:0]  addr_i,
    input logic [31:0] wdata_i,
    input logic        wr_i,
    input logic        rd_i,
    input logic [31:0] rdata_o,
    input logic [3:0]  fwd_lim_i,
    input logic [3:0]  rev_lim_i,
    input logic [3:0]  home_i,
    input logic [3:0]  pha_i,
    input logic [3:0]  phb_i,
    input logic [3:0]  idx_i,
    input logic [3:0]  move_pos_req_i,
    input logic [3:0]  move_neg_req_i,
    input logic [3:0]  halt_o,
    input logic [3:0]  move_pos_ok_o,
    input logic [3:0]  move_neg_ok_o
);
    logic [11:0] en_q;
    logic [11:0] pol_q;
    logic [3:0]  en_ax;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////////////
    // Shadow copies of enable and polarity
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_q  <= `LIM_EN_RST;
            pol_q <= `LIM_POL_RST;
        end else if (wr_i && addr_i == `ADDR_LIM_EN) begin
            en_q <= wdata_i[11:0];
        end else if (wr_i && addr_i == `ADDR_LIM_POL) begin
            pol_q <= wdata_i[11:0];
        end
    end
    assign en_ax = {|en_q[11:9], |en_q[8:6], |en_q[5:3], |en_q[2:0]};
    ////////////////////////////////////////////////////////////////////////////////
    // Bus, halt and permit relations
    rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
        else $error("read data not zero outside read answer");
    narrow_read_a: assert property ($past(rd_i) && $past(addr_i) == `ADDR_LIM_STAT
        |-> rdata_o[31:12] == 20'h0) else $error("status upper bits not zero");
    en_readback_a: assert property ($past(rd_i) && $past(addr_i) == `ADDR_LIM_EN
        |-> rdata_o == {20'h0, en_q}) else $error("enable readback wrong");
    pol_readback_a: assert property ($past(rd_i) && $past(addr_i) == `ADDR_LIM_POL
        |-> rdata_o == {20'h0, pol_q}) else $error("polarity readback wrong");
    halt_pulse_a: assert property ((halt_o & $past(halt_o)) == 4'h0)
        else $error("halt longer than one cycle");
    halt_enabled_a: assert property ((halt_o & ~$past(en_ax)) == 4'h0)
        else $error("halt on axis with no enabled input");
    pos_ok_a: assert property ((move_pos_ok_o & ~$past(move_pos_req_i)) == 4'h0)
        else $error("positive permit without request");
    neg_ok_a: assert property ((move_neg_ok_o & ~$past(move_neg_req_i)) == 4'h0)
        else $error("negative permit without request");
    halt_seen_c: cover property (halt_o != 4'h0);
    pos_block_c: cover property ($past(move_pos_req_i[0]) && !move_pos_ok_o[0]);
    stat_read_c: cover property ($past(rd_i) && $past(addr_i) == `ADDR_LIM_STAT);
endmodule
bind limit_home_quadrature_inputs limit_home_quadrature_inputs_monitor #(
    .LIM_FILT_CYC(LIM_FILT_CYC)
) mon (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .fwd_lim_i(fwd_lim_i), .rev_lim_i(rev_lim_i),
    .home_i(home_i), .pha_i(pha_i), .phb_i(phb_i), .idx_i(idx_i),
    .move_pos_req_i(move_pos_req_i), .move_neg_req_i(move_neg_req_i), .halt_o(halt_o),
    .move_pos_ok_o(move_pos_ok_o), .move_neg_ok_o(move_neg_ok_o));

// ---- quad_encoder_model.sv ----
// Behavioural quadrature encoder moved by step commands
module quad_encoder_model (
    input  logic       clk_i,
    input  logic [3:0] up_i,
    input  logic [3:0] dn_i,
    input  logic [3:0] bump_i,
    input  logic [3:0] zreq_i,
    output logic [3:0] pha_o,
    output logic [3:0] phb_o,
    output logic [3:0] idx_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] st_q [4] = '{2'h0, 2'h0, 2'h0, 2'h0};
    // One quarter cycle per step keeps phases 90 degrees apart; bump jumps two
    always @(posedge clk_i) begin
        foreach (st_q[n]) begin
            st_q[n] <= st_q[n] + {1'b0, up_i[n]} - {1'b0, dn_i[n]} + {bump_i[n], 1'b0};
        end
    end
    // Gray phases, A leads when counting up; index only when asked
    always_comb begin
        foreach (st_q[n]) begin
            pha_o[n] = st_q[n][1] ^ st_q[n][0];
            phb_o[n] = st_q[n][1];
        end
        idx_o = zreq_i;
    end
endmodule

// ---- limit_home_quadrature_inputs_bench.sv ----
// Self-checking bench for limit conditioning and encoder counting
`include "axis_io_regs.vh"
module limit_home_quadrature_inputs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, rst_i, wr_i, rd_i;
    logic [7:0] addr_i;
    logic [31:0] wdata_i, rdata_o, rv;
    logic [3:0] fwd_lim_i, rev_lim_i, home_i, pha_i, phb_i, idx_i, move_pos_req_i;
    logic [3:0] move_neg_req_i, halt_o, move_pos_ok_o, move_neg_ok_o;
    logic [3:0] up, dn, bump, zreq, u, d;
    logic [31:0] exp_cnt [4] = '{0, 0, 0, 0};
    logic [31:0] halt_cnt [4];
    int ph [4] = '{0, 0, 0, 0};
    int errors = 0, compares = 0, cyc = 0;
    limit_home_quadrature_inputs #(.LIM_FILT_CYC(18'd8)) DUT (.clk_i(clk_i), .rst_i(rst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .fwd_lim_i(fwd_lim_i), .rev_lim_i(rev_lim_i), .home_i(home_i), .pha_i(pha_i),
        .phb_i(phb_i), .idx_i(idx_i), .move_pos_req_i(move_pos_req_i),
        .move_neg_req_i(move_neg_req_i), .halt_o(halt_o), .move_pos_ok_o(move_pos_ok_o),
        .move_neg_ok_o(move_neg_ok_o));
    quad_encoder_model enc (.clk_i(clk_i), .up_i(up), .dn_i(dn), .bump_i(bump),
        .zreq_i(zreq), .pha_o(pha_i), .phb_o(phb_i), .idx_o(idx_i));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock, halt tally and hang guard
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        foreach (halt_cnt[n]) halt_cnt[n] <= rst_i ? 32'h0 : halt_cnt[n] + halt_o[n];
        if (cyc == 20000) begin
            errors++;
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Bus, stimulus and comparison tasks
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, want, seen);
        end
    endtask
    task automatic step(input logic [3:0] su, input logic [3:0] sd, input logic [3:0] sb);
        @(posedge clk_i);
        up <= su;
        dn <= sd;
        bump <= sb;
        @(posedge clk_i);
        up <= 4'h0;
        dn <= 4'h0;
        bump <= 4'h0;
        for (int n = 0; n < 4; n++) begin
            exp_cnt[n] = exp_cnt[n] + su[n] - sd[n];
            ph[n] = (ph[n] + su[n] - sd[n] + 2 * sb[n]) & 3;
        end
        repeat (12) @(posedge clk_i);
    endtask
    task automatic chkcnt();
        for (int n = 0; n < 4; n++) begin
            rd(`ADDR_ENC_CNT0 + 8'(4 * n), rv);
            chk("count", rv, exp_cnt[n]);
        end
    endtask
    task automatic zpulse(input logic [3:0] m);
        @(posedge clk_i);
        zreq <= m;
        repeat (10) @(posedge clk_i);
        zreq <= 4'h0;
        repeat (12) @(posedge clk_i);
    endtask
    task automatic lim(input logic [3:0] f, input logic [3:0] r, input logic [3:0] h, int n);
        @(posedge clk_i);
        fwd_lim_i <= f;
        rev_lim_i <= r;
        home_i <= h;
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic test_done();
        if (errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {rst_i, wr_i, rd_i, addr_i, wdata_i} = {1'b1, 42'h0};
        {fwd_lim_i, rev_lim_i, home_i, up, dn, bump, zreq} = 28'h0;
        {move_pos_req_i, move_neg_req_i} = 8'hff;
        void'($urandom(81293));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`ADDR_LIM_POL, rv);
        chk("lim_pol", rv, 32'hfff);
        rd(`ADDR_ENC_FILT, rv);
        chk("enc_filt", rv, 32'h3);
        rd(8'h3c, rv);
        chk("unmapped", rv, 32'h0);
        step(4'h0, 4'h1, 4'h0);
        chkcnt();
        step(4'h1, 4'h0, 4'h0);
        chkcnt();
        repeat (40) begin
            u = 4'($urandom);
            d = ~u & 4'($urandom);
            step(u, d, 4'h0);
        end
        chkcnt();
        step(4'h0, 4'h0, 4'hf);
        chkcnt();
        while (ph[0] != 0 || ph[1] != 0) step({2'b0, ph[1] != 0, ph[0] != 0}, 4'h0, 4'h0);
        wr(`ADDR_ENC_QUAL, 32'h0c);
        wr(`ADDR_REF_ARM, 32'h3);
        zpulse(4'h3);
        rd(`ADDR_REF_STAT, rv);
        chk("found", rv, 32'h1);
        rd(`ADDR_ENC_CAP0, rv);
        chk("capture", rv, exp_cnt[0]);
        step(4'h2, 4'h0, 4'h0);
        step(4'h2, 4'h0, 4'h0);
        zpulse(4'h2);
        rd(`ADDR_REF_STAT, rv);
        chk("found", rv, 32'h3);
        rd(`ADDR_ENC_CAP0 + 8'h4, rv);
        chk("capture", rv, exp_cnt[1]);
        wr(`ADDR_ENC_POL, 32'h1);
        exp_cnt[0] = exp_cnt[0] + 32'h1;
        repeat (12) @(posedge clk_i);
        chkcnt();
        wr(`ADDR_LIM_EN, 32'h7);
        rd(`ADDR_LIM_EN, rv);
        chk("lim_en", rv, 32'h7);
        lim(4'h1, 4'h0, 4'h0, 4);
        lim(4'h0, 4'h0, 4'h0, 20);
        chk("halts", halt_cnt[0], 32'h0);
        lim(4'h1, 4'h0, 4'h0, 16);
        chk("halts", halt_cnt[0], 32'h1);
        chk("pos_ok", {28'h0, move_pos_ok_o}, 32'he);
        chk("neg_ok", {28'h0, move_neg_ok_o}, 32'hf);
        rd(`ADDR_LIM_STAT, rv);
        chk("status", rv, 32'h1);
        lim(4'h0, 4'h0, 4'h0, 16);
        chk("pos_ok", {28'h0, move_pos_ok_o}, 32'hf);
        wr(`ADDR_LIM_CFG, 32'h1);
        lim(4'h0, 4'h1, 4'h0, 2);
        lim(4'h0, 4'h0, 4'h0, 10);
        chk("halts", halt_cnt[0], 32'h2);
        chk("neg_ok", {28'h0, move_neg_ok_o}, 32'hf);
        rd(`ADDR_LIM_EVT, rv);
        chk("lim_evt", rv, 32'h3);
        wr(`ADDR_LIM_EVT, 32'h1);
        rd(`ADDR_LIM_EVT, rv);
        chk("lim_evt", rv, 32'h2);
        lim(4'h0, 4'h0, 4'h8, 6);
        rd(`ADDR_LIM_STAT, rv);
        chk("status", rv, 32'h800);
        chk("halts", halt_cnt[3], 32'h0);
        wr(`ADDR_LIM_POL, 32'h7ff);
        rd(`ADDR_LIM_STAT, rv);
        chk("status", rv, 32'h0);
        test_done();
    end
endmodule
